// file: rtl/lpcdw_pkg.sv
package lpcdw_pkg;
  // field codes on the four address/data lines
  localparam logic [3:0] LAD_START  = 4'h0;
  localparam logic [3:0] LAD_DMA_WR = 4'hA;
  localparam logic [2:0] CT_DMA_WR  = 3'h5;
  localparam logic [1:0] SIZE_16    = 2'h1;
  localparam logic [3:0] SIZE_FIELD = 4'h1;
  localparam logic [3:0] SYNC_MORE  = 4'h9;
  localparam logic [3:0] SYNC_DONE  = 4'h0;
  localparam logic [3:0] LAD_HIGH   = 4'hF;
  localparam int         TC_BIT     = 3;
  localparam int         WORD_W     = 16;
  // request line serial frame: start, three channel bits, active, deassert
  localparam logic [2:0] LDRQ_BITS  = 3'h6;
  localparam logic [2:0] DMA_CH_DEF = 3'h5;
  localparam logic       LDRQ_IDLE  = 1'b1;
  // power-down lead time before the bus clock may stop
  localparam int PD_LEAD_US  = 30;
  localparam int CLK_MHZ     = 100;
  localparam int PD_LEAD_CYC = PD_LEAD_US * CLK_MHZ;

  typedef enum logic [3:0] {
    P_IDLE  = 4'h0, P_CYC = 4'h1, P_CHAN = 4'h2, P_SIZE  = 4'h3,
    P_HTAR  = 4'h4, P_HTURN = 4'h5, P_SYNC = 4'h6, P_NLO = 4'h7,
    P_NHI   = 4'h8, P_DTAR = 4'h9, P_DTURN = 4'hA
  } lpcdw_pstate_t;

  typedef enum logic [3:0] {
    H_IDLE = 4'h0, H_START = 4'h1, H_CYC = 4'h2, H_CHAN = 4'h3,
    H_SIZE = 4'h4, H_TAR = 4'h5, H_TURN = 4'h6, H_SYNC = 4'h7,
    H_NLO  = 4'h8, H_NHI = 4'h9, H_PTAR = 4'hA, H_PTURN = 4'hB
  } lpcdw_hstate_t;
endpackage

// file: rtl/lpcdw_if.sv
`timescale 1ns/100ps
interface lpcdw_if;
  logic [3:0] host_lad;
  logic       host_lad_oe;
  logic       lframe_n;
  logic       lreset_n;
  logic       lpcpd_n;
  logic [3:0] per_lad;
  logic       per_lad_oe;
  logic       ldrq_n_out;
  logic       ldrq_oe;
  logic [3:0] lad;
  logic       ldrq_n;

  // wire levels; undriven lines float high on pull-ups
  assign lad    = host_lad_oe ? host_lad : (per_lad_oe ? per_lad : 4'hF);
  assign ldrq_n = ldrq_oe ? ldrq_n_out : 1'b1;

  modport host (output host_lad, host_lad_oe, lframe_n, lreset_n, lpcpd_n, input lad, ldrq_n);
  modport periph (output per_lad, per_lad_oe, ldrq_n_out, ldrq_oe,
                  input lad, lframe_n, lreset_n, lpcpd_n);
endinterface

// file: rtl/lpcdw_fifo.sv
`timescale 1ns/100ps
module lpcdw_fifo #(
  parameter int W     = 16,
  parameter int DEPTH = 2
) (
  input  wire logic         clock_i,
  input  wire logic         srst_i,
  input  wire logic [W-1:0] wr_data_i,
  input  wire logic         wr_valid_i,
  output logic              wr_ready_o,
  output logic [W-1:0]      rd_data_o,
  output logic              rd_valid_o,
  input  wire logic         rd_ready_i,
  output logic [1:0]        count_o
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  logic [W-1:0]  mem_ff [DEPTH];
  logic [AW-1:0] wp_ff;
  logic [AW-1:0] rp_ff;
  logic [AW:0]   cnt_ff;
  logic          push;
  logic          pop;

  assign wr_ready_o = (cnt_ff != (AW+1)'(DEPTH));
  assign rd_valid_o = (cnt_ff != '0);
  assign rd_data_o  = mem_ff[rp_ff];
  assign push       = wr_valid_i & wr_ready_o;
  assign pop        = rd_ready_i & rd_valid_o;
  assign count_o    = (cnt_ff > (AW+1)'(1)) ? 2'h2 : 2'(cnt_ff);

  // storage has no reset; only the pointers matter
  always_ff @(posedge clock_i)
    if (push)
      mem_ff[wp_ff] <= wr_data_i;

  // pointers wrap at depth
  always_ff @(posedge clock_i)
    if (srst_i)
    begin
      wp_ff  <= '0;
      rp_ff  <= '0;
      cnt_ff <= '0;
    end
    else
    begin
      if (push)
        wp_ff <= (wp_ff == AW'(DEPTH-1)) ? '0 : AW'(wp_ff + 1'b1);
      if (pop)
        rp_ff <= (rp_ff == AW'(DEPTH-1)) ? '0 : AW'(rp_ff + 1'b1);
      cnt_ff <= (AW+1)'(cnt_ff + push - pop);
    end
endmodule // lpcdw_fifo

// file: rtl/lpcdw_periph.sv
`timescale 1ns/100ps
module lpcdw_periph #(
  parameter logic [2:0] DMA_CH = lpcdw_pkg::DMA_CH_DEF,
  parameter int         WIDTH  = lpcdw_pkg::WORD_W
) (
  input  wire logic             clock_i,
  input  wire logic             srst_i,
  lpcdw_if.periph               bus,
  input  wire logic [WIDTH-1:0] wr_data_i,
  input  wire logic             wr_valid_i,
  output logic                  wr_ready_o,
  output logic                  word_sent_o,
  output logic                  tc_o,
  output logic                  pd_o
);
  ////////////////////////////////////////////////////////////////////////////
  // declarations
  lpcdw_pkg::lpcdw_pstate_t state_ff;
  lpcdw_pkg::lpcdw_pstate_t nxt_state;
  logic             bus_rst;
  logic             pd_act;
  logic             byte_ff;
  logic             nxt_byte;
  logic             tc_ff;
  logic [3:0]       lad_ff;
  logic             lad_oe_ff;
  logic [3:0]       nxt_lad;
  logic             nxt_lad_oe;
  logic [WIDTH-1:0] word;
  logic [7:0]       cur_byte;
  logic             fifo_valid;
  logic             pop;
  logic [1:0]       fifo_cnt;
  logic             more;
  logic             acked;
  logic [5:0]       rq_sh_ff;
  logic [2:0]       rq_cnt_ff;
  logic             rq_wait_ff;
  logic             rq_load;
  logic             ldrq_ff;
  logic             ldrq_oe_ff;
  logic             sent_ff;
  logic             tc_out_ff;

  ////////////////////////////////////////////////////////////////////////////
  // reset of the bus block only; the word buffer keeps its contents
  assign pd_act  = ~bus.lpcpd_n;
  assign bus_rst = srst_i | ~bus.lreset_n | pd_act;
  assign pd_o    = pd_act;

  // two-entry buffer so a late acknowledge loses no word
  lpcdw_fifo #(
    .W     (WIDTH),
    .DEPTH (2)
  ) u_buf (
    .clock_i    (clock_i),
    .srst_i     (srst_i),
    .wr_data_i  (wr_data_i),
    .wr_valid_i (wr_valid_i),
    .wr_ready_o (wr_ready_o),
    .rd_data_o  (word),
    .rd_valid_o (fifo_valid),
    .rd_ready_i (pop),
    .count_o    (fifo_cnt)
  );

  // more wanted if another word is buffered or on its way
  assign more     = (fifo_cnt == 2'h2) | wr_valid_i;
  // a tc channel field is an acknowledge too, else the request would hang
  assign acked    = (state_ff == lpcdw_pkg::P_CHAN) & (bus.lad[2:0] == DMA_CH)
                  & fifo_valid & rq_wait_ff;
  assign pop      = (state_ff == lpcdw_pkg::P_NHI) & byte_ff;
  assign cur_byte = nxt_byte ? word[15:8] : word[7:0];

  ////////////////////////////////////////////////////////////////////////////
  // cycle decoder; anything but our DMA write drops back to idle
  always_comb
  begin
    nxt_state = state_ff;
    nxt_byte  = byte_ff;
    unique case (state_ff)
      lpcdw_pkg::P_IDLE:
        if (~bus.lframe_n && bus.lad == lpcdw_pkg::LAD_START)
          nxt_state = lpcdw_pkg::P_CYC;
      lpcdw_pkg::P_CYC:
        if (~bus.lframe_n && bus.lad == lpcdw_pkg::LAD_START)
          nxt_state = lpcdw_pkg::P_CYC;
        else if (~bus.lframe_n)
          nxt_state = lpcdw_pkg::P_IDLE;
        else if (bus.lad[3:1] == lpcdw_pkg::CT_DMA_WR)
          nxt_state = lpcdw_pkg::P_CHAN;
        else
          nxt_state = lpcdw_pkg::P_IDLE;
      lpcdw_pkg::P_CHAN:
      begin
        // tc words share the ack check, top bit aside
        if ((bus.lad[2:0] == DMA_CH) && fifo_valid && rq_wait_ff)
          nxt_state = lpcdw_pkg::P_SIZE;
        else
          nxt_state = lpcdw_pkg::P_IDLE;
      end
      lpcdw_pkg::P_SIZE:
        nxt_state = (bus.lad[1:0] == lpcdw_pkg::SIZE_16) ? lpcdw_pkg::P_HTAR : lpcdw_pkg::P_IDLE;
      lpcdw_pkg::P_HTAR:
        nxt_state = lpcdw_pkg::P_HTURN;
      lpcdw_pkg::P_HTURN:
      begin
        nxt_state = lpcdw_pkg::P_SYNC;
        nxt_byte  = 1'b0;
      end
      lpcdw_pkg::P_SYNC:
        nxt_state = lpcdw_pkg::P_NLO;
      lpcdw_pkg::P_NLO:
        nxt_state = lpcdw_pkg::P_NHI;
      lpcdw_pkg::P_NHI:
        if (byte_ff)
          nxt_state = lpcdw_pkg::P_DTAR;
        else
        begin
          nxt_state = lpcdw_pkg::P_SYNC;
          nxt_byte  = 1'b1;
        end
      lpcdw_pkg::P_DTAR:
        nxt_state = lpcdw_pkg::P_DTURN;
      lpcdw_pkg::P_DTURN:
        nxt_state = lpcdw_pkg::P_IDLE;
      default:
        nxt_state = lpcdw_pkg::P_IDLE;
    endcase
  end

  // line drive chosen from the state being entered, so it is a flop
  always_comb
  begin
    nxt_lad    = lpcdw_pkg::LAD_HIGH;
    nxt_lad_oe = 1'b0;
    unique case (nxt_state)
      lpcdw_pkg::P_SYNC:
      begin
        nxt_lad_oe = 1'b1;
        // second byte of the final word says no more
        nxt_lad    = (nxt_byte && (tc_ff || !more)) ? lpcdw_pkg::SYNC_DONE : lpcdw_pkg::SYNC_MORE;
      end
      lpcdw_pkg::P_NLO:
      begin
        nxt_lad_oe = 1'b1;
        nxt_lad    = cur_byte[3:0];
      end
      lpcdw_pkg::P_NHI:
      begin
        nxt_lad_oe = 1'b1;
        nxt_lad    = cur_byte[7:4];
      end
      lpcdw_pkg::P_DTAR:
      begin
        nxt_lad_oe = 1'b1;
        nxt_lad    = lpcdw_pkg::LAD_HIGH;
      end
      default:
      begin
        nxt_lad_oe = 1'b0;
        nxt_lad    = lpcdw_pkg::LAD_HIGH;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // state and byte pointer
  always_ff @(posedge clock_i)
    if (bus_rst)
    begin
      state_ff <= lpcdw_pkg::P_IDLE;
      byte_ff  <= 1'b0;
    end
    else
    begin
      state_ff <= nxt_state;
      byte_ff  <= nxt_byte;
    end

  // terminal count caught from the channel field
  always_ff @(posedge clock_i)
    if (bus_rst)
      tc_ff <= 1'b0;
    else if (state_ff == lpcdw_pkg::P_CHAN)
      tc_ff <= bus.lad[lpcdw_pkg::TC_BIT];

  // registered line drive
  always_ff @(posedge clock_i)
    if (bus_rst)
    begin
      lad_ff    <= lpcdw_pkg::LAD_HIGH;
      lad_oe_ff <= 1'b0;
    end
    else
    begin
      lad_ff    <= nxt_lad;
      lad_oe_ff <= nxt_lad_oe;
    end

  assign bus.per_lad    = lad_ff;
  assign bus.per_lad_oe = lad_oe_ff;

  ////////////////////////////////////////////////////////////////////////////
  // request encoder: one request per buffered word, only from idle,
  // so the word in flight is never requested twice
  assign rq_load = (state_ff == lpcdw_pkg::P_IDLE) & fifo_valid & ~rq_wait_ff & (rq_cnt_ff == 3'h0);

  always_ff @(posedge clock_i)
    if (bus_rst)
    begin
      rq_sh_ff   <= 6'h3F;
      rq_cnt_ff  <= 3'h0;
      rq_wait_ff <= 1'b0;
    end
    else
    begin
      if (rq_load)
      begin
        rq_sh_ff  <= {1'b0, DMA_CH, 1'b1, 1'b1};
        rq_cnt_ff <= lpcdw_pkg::LDRQ_BITS;
      end
      else if (rq_cnt_ff != 3'h0)
      begin
        rq_sh_ff  <= {rq_sh_ff[4:0], 1'b1};
        rq_cnt_ff <= rq_cnt_ff - 3'h1;
      end
      if (rq_load)
        rq_wait_ff <= 1'b1;
      else if (acked)
        rq_wait_ff <= 1'b0;
    end

  // request pin: released in power-down so the line floats high, driven high when idle
  always_ff @(posedge clock_i)
    if (srst_i || pd_act)
    begin
      ldrq_ff    <= 1'b0;
      ldrq_oe_ff <= 1'b0;
    end
    else
    begin
      ldrq_oe_ff <= 1'b1;
      ldrq_ff    <= (rq_cnt_ff != 3'h0) ? rq_sh_ff[5] : lpcdw_pkg::LDRQ_IDLE;
    end

  assign bus.ldrq_n_out = ldrq_ff;
  assign bus.ldrq_oe    = ldrq_oe_ff;

  ////////////////////////////////////////////////////////////////////////////
  // user-side status pulses
  always_ff @(posedge clock_i)
    if (bus_rst)
    begin
      sent_ff   <= 1'b0;
      tc_out_ff <= 1'b0;
    end
    else
    begin
      sent_ff   <= pop;
      tc_out_ff <= pop & tc_ff;
    end

  assign word_sent_o = sent_ff;
  assign tc_o        = tc_out_ff;
endmodule // lpcdw_periph

// file: rtl/lpcdw_host.sv
`timescale 1ns/100ps
module lpcdw_host #(
  parameter int PD_CYC = lpcdw_pkg::PD_LEAD_CYC
) (
  input  wire logic        clock_i,
  input  wire logic        srst_i,
  lpcdw_if.host            bus,
  input  wire logic        bus_rst_i,
  input  wire logic        pd_req_i,
  input  wire logic        start_i,
  input  wire logic [7:0]  words_i,
  output logic [15:0]      data_o,
  output logic             data_valid_o,
  output logic             tc_o,
  output logic             done_o,
  output logic             pd_safe_o
);
  lpcdw_pkg::lpcdw_hstate_t state_ff;
  lpcdw_pkg::lpcdw_hstate_t nxt_state;
  logic        byte_ff;
  logic [7:0]  left_ff;
  logic [15:0] data_ff;
  logic [3:0]  lad_ff;
  logic        lad_oe_ff;
  logic        frame_ff;
  logic [2:0]  dq_cnt_ff;
  logic [2:0]  dq_ch_ff;
  logic        pend_ff;
  logic [2:0]  pend_ch_ff;
  logic        pd_ff;
  logic        rst_ff;
  logic [11:0] pd_cnt_ff;
  logic        go;
  logic        last;
  logic        vld_ff;
  logic        tc_ff;
  logic        done_ff;

  ////////////////////////////////////////////////////////////////////////////
  // a word cycle starts only with a pending request and no power-down
  assign go   = (state_ff == lpcdw_pkg::H_IDLE) & pend_ff & (left_ff != 8'h0) & ~pd_ff;
  assign last = (left_ff == 8'h1);

  always_comb
  begin
    nxt_state = state_ff;
    unique case (state_ff)
      lpcdw_pkg::H_IDLE:  if (go) nxt_state = lpcdw_pkg::H_START;
      lpcdw_pkg::H_START: nxt_state = lpcdw_pkg::H_CYC;
      lpcdw_pkg::H_CYC:   nxt_state = lpcdw_pkg::H_CHAN;
      lpcdw_pkg::H_CHAN:  nxt_state = lpcdw_pkg::H_SIZE;
      lpcdw_pkg::H_SIZE:  nxt_state = lpcdw_pkg::H_TAR;
      lpcdw_pkg::H_TAR:   nxt_state = lpcdw_pkg::H_TURN;
      lpcdw_pkg::H_TURN:  nxt_state = lpcdw_pkg::H_SYNC;
      // wait codes from other targets simply hold here
      lpcdw_pkg::H_SYNC:
        if (bus.lad == lpcdw_pkg::SYNC_MORE || bus.lad == lpcdw_pkg::SYNC_DONE)
          nxt_state = lpcdw_pkg::H_NLO;
      lpcdw_pkg::H_NLO:   nxt_state = lpcdw_pkg::H_NHI;
      lpcdw_pkg::H_NHI:   nxt_state = byte_ff ? lpcdw_pkg::H_PTAR : lpcdw_pkg::H_SYNC;
      lpcdw_pkg::H_PTAR:  nxt_state = lpcdw_pkg::H_PTURN;
      lpcdw_pkg::H_PTURN: nxt_state = lpcdw_pkg::H_IDLE;
      default:            nxt_state = lpcdw_pkg::H_IDLE;
    endcase
  end

  always_ff @(posedge clock_i)
    if (srst_i)
    begin
      state_ff <= lpcdw_pkg::H_IDLE;
      byte_ff  <= 1'b0;
    end
    else
    begin
      state_ff <= nxt_state;
      if (state_ff == lpcdw_pkg::H_TURN)
        byte_ff <= 1'b0;
      else if (state_ff == lpcdw_pkg::H_NHI)
        byte_ff <= 1'b1;
    end

  // host fields, registered from the state being entered
  always_ff @(posedge clock_i)
    if (srst_i)
    begin
      lad_ff    <= lpcdw_pkg::LAD_HIGH;
      lad_oe_ff <= 1'b0;
      frame_ff  <= 1'b1;
    end
    else
    begin
      frame_ff  <= (nxt_state != lpcdw_pkg::H_START);
      lad_oe_ff <= (nxt_state inside {lpcdw_pkg::H_START, lpcdw_pkg::H_CYC, lpcdw_pkg::H_CHAN,
                                      lpcdw_pkg::H_SIZE, lpcdw_pkg::H_TAR});
      unique case (nxt_state)
        lpcdw_pkg::H_START: lad_ff <= lpcdw_pkg::LAD_START;
        lpcdw_pkg::H_CYC:   lad_ff <= lpcdw_pkg::LAD_DMA_WR;
        lpcdw_pkg::H_CHAN:  lad_ff <= {last, pend_ch_ff};
        lpcdw_pkg::H_SIZE:  lad_ff <= lpcdw_pkg::SIZE_FIELD;
        default:            lad_ff <= lpcdw_pkg::LAD_HIGH;
      endcase
    end

  assign bus.host_lad    = lad_ff;
  assign bus.host_lad_oe = lad_oe_ff;
  assign bus.lframe_n    = frame_ff;

  ////////////////////////////////////////////////////////////////////////////
  // request decoder; a new request wins over the clear at cycle start
  always_ff @(posedge clock_i)
    if (srst_i || pd_ff)
    begin
      dq_cnt_ff  <= 3'h0;
      dq_ch_ff   <= 3'h0;
      pend_ff    <= 1'b0;
      pend_ch_ff <= 3'h0;
    end
    else
    begin
      if (dq_cnt_ff == 3'h0)
      begin
        if (!bus.ldrq_n)
          dq_cnt_ff <= 3'h1;
      end
      else if (dq_cnt_ff == 3'h4)
        dq_cnt_ff <= 3'h0;
      else
      begin
        dq_ch_ff  <= {dq_ch_ff[1:0], bus.ldrq_n};
        dq_cnt_ff <= dq_cnt_ff + 3'h1;
      end
      if (dq_cnt_ff == 3'h4 && bus.ldrq_n)
      begin
        pend_ff    <= 1'b1;
        pend_ch_ff <= dq_ch_ff;
      end
      else if (go)
        pend_ff <= 1'b0;
    end

  ////////////////////////////////////////////////////////////////////////////
  // word count, data capture and user pulses
  always_ff @(posedge clock_i)
    if (srst_i)
    begin
      left_ff <= 8'h0;
      data_ff <= 16'h0;
      vld_ff  <= 1'b0;
      tc_ff   <= 1'b0;
      done_ff <= 1'b0;
    end
    else
    begin
      vld_ff  <= 1'b0;
      tc_ff   <= 1'b0;
      done_ff <= 1'b0;
      if (start_i)
        left_ff <= words_i;
      else if (state_ff == lpcdw_pkg::H_PTAR)
      begin
        vld_ff  <= 1'b1;
        tc_ff   <= last;
        left_ff <= left_ff - 8'h1;
      end
      // a no-more sync on the second byte ends the transfer early
      if (state_ff == lpcdw_pkg::H_SYNC && byte_ff && bus.lad == lpcdw_pkg::SYNC_DONE && !last)
      begin
        done_ff <= 1'b1;
        left_ff <= 8'h1;
      end
      if (state_ff == lpcdw_pkg::H_NLO)
      begin
        if (byte_ff)
          data_ff[11:8] <= bus.lad;
        else
          data_ff[3:0] <= bus.lad;
      end
      if (state_ff == lpcdw_pkg::H_NHI)
      begin
        if (byte_ff)
          data_ff[15:12] <= bus.lad;
        else
          data_ff[7:4] <= bus.lad;
      end
    end

  assign data_o       = data_ff;
  assign data_valid_o = vld_ff;
  assign tc_o         = tc_ff;
  assign done_o       = done_ff;

  ////////////////////////////////////////////////////////////////////////////
  // power-down and bus reset pins; safe flag after the lead time
  always_ff @(posedge clock_i)
    if (srst_i)
    begin
      pd_ff     <= 1'b0;
      rst_ff    <= 1'b1;
      pd_cnt_ff <= 12'h0;
    end
    else
    begin
      pd_ff  <= pd_req_i;
      rst_ff <= bus_rst_i;
      if (!pd_ff)
        pd_cnt_ff <= 12'h0;
      else if (pd_cnt_ff != 12'(PD_CYC))
        pd_cnt_ff <= pd_cnt_ff + 12'h1;
    end

  assign bus.lpcpd_n = ~pd_ff;
  assign bus.lreset_n = ~rst_ff;
  assign pd_safe_o   = pd_ff & (pd_cnt_ff == 12'(PD_CYC));
endmodule // lpcdw_host

// file: tb/lpcdw_chk.sv
`timescale 1ns/100ps
module lpcdw_chk #(
  parameter logic [2:0] DMA_CH = lpcdw_pkg::DMA_CH_DEF
) (
  input wire logic       clock_i,
  input wire logic       srst_i,
  input wire logic [3:0] lad,
  input wire logic       host_lad_oe,
  input wire logic       per_lad_oe,
  input wire logic       lframe_n,
  input wire logic       lreset_n,
  input wire logic       lpcpd_n,
  input wire logic       ldrq_oe,
  input wire logic       ldrq_n
);
  default clocking cb @(posedge clock_i);
  endclocking
  default disable iff (srst_i);

  // frame low for one cycle, then the header begins
  sequence hdr_s;
    !lframe_n ##1 lframe_n;
  endsequence

  ////////////////////////////////////////////////////////////////////////////////
  start_code_a: assert property (!lframe_n |-> host_lad_oe && lad == lpcdw_pkg::LAD_START)
    else $error("frame low without start code");
  hdr_fields_a: assert property (hdr_s |-> lad == lpcdw_pkg::LAD_DMA_WR ##1 lad[2:0] == DMA_CH
    ##1 lad == lpcdw_pkg::SIZE_FIELD ##1 host_lad_oe && lad == 4'hF ##1 !host_lad_oe && !per_lad_oe)
    else $error("host header fields wrong");
  // both syncs, the high drive and the release, timed from the header
  sync_answer_a: assert property (hdr_s |-> ##5 per_lad_oe && lad == lpcdw_pkg::SYNC_MORE
    ##3 per_lad_oe && (lad == lpcdw_pkg::SYNC_MORE || lad == lpcdw_pkg::SYNC_DONE)
    ##3 per_lad_oe && lad == 4'hF ##1 !per_lad_oe && !host_lad_oe)
    else $error("peripheral answer out of order");
  tc_sync_a: assert property (hdr_s ##1 lad[3] |-> ##7 lad == lpcdw_pkg::SYNC_DONE)
    else $error("last word without done sync");
  // peripheral never drives unless a start came six cycles before
  idle_quiet_a: assert property ($rose(per_lad_oe) |-> $past(lframe_n, 6) == 1'b0)
    else $error("peripheral drove without start");
  // three idle ones guard against a zero inside the channel bits
  req_serial_a: assert property (disable iff (srst_i || !lpcpd_n || !lreset_n)
    ldrq_n [*3] ##1 !ldrq_n |-> ##1 ldrq_n == DMA_CH[2] ##1 ldrq_n == DMA_CH[1]
    ##1 ldrq_n == DMA_CH[0] ##1 ldrq_n [*2])
    else $error("request frame wrong");
  // bus reset keeps the request line driven high; only power-down or srst_i releases it
  pd_quiet_a: assert property (!lpcpd_n || !lreset_n |=> !per_lad_oe && ($past(lpcpd_n) || !ldrq_oe))
    else $error("bus block active in power-down");
  pd_no_start_a: assert property (!lpcpd_n |=> lframe_n)
    else $error("frame started in power-down");
  pd_exit_a: assert property ($rose(lpcpd_n) && lreset_n |-> ##1 ldrq_oe && ldrq_n)
    else $error("request line not high after power-down");

  cover property (hdr_s ##1 lad[3]);
  cover property ($rose(lpcpd_n));
  cover property (ldrq_n [*3] ##1 !ldrq_n);
endmodule // lpcdw_chk

// file: tb/lpc_dma_write_and_powerdown_test.sv
`timescale 1ns/100ps
module lpc_dma_write_and_powerdown_test;
  localparam logic [2:0] CH = 3'h6;
  logic        clock_i = 1'b0;
  logic        srst_i  = 1'b1;
  logic        bus_rst = 1'b0;
  logic        pd_req  = 1'b0;
  logic        start   = 1'b0;
  logic        wr_valid = 1'b0;
  logic        exp_tc  = 1'b0;
  logic [7:0]  words   = 8'h00;
  logic [15:0] wr_data = 16'h0000;
  logic [31:0] lfsr    = 32'h2CA797FF;
  logic [15:0] h_data;
  logic        wr_ready, p_sent, p_tc, pd_o, h_valid, h_tc, h_done, pd_safe;
  logic [15:0] exp_q[$];
  int          miscompares = 0, n_checks = 0, cycles = 0, cyc = -1;
  int          wseq = 0, got = 0, n_exp = 0, dones = 0;
  bit          early = 1'b0;

  always #5 clock_i = ~clock_i;

  lpcdw_if bus_if ();
  lpcdw_host #(.PD_CYC(20)) lpcdw_host_inst (.clock_i(clock_i), .srst_i(srst_i), .bus(bus_if),
    .bus_rst_i(bus_rst), .pd_req_i(pd_req), .start_i(start), .words_i(words), .data_o(h_data),
    .data_valid_o(h_valid), .tc_o(h_tc), .done_o(h_done), .pd_safe_o(pd_safe));
  lpcdw_periph #(.DMA_CH(CH)) lpcdw_periph_inst (.clock_i(clock_i), .srst_i(srst_i), .bus(bus_if),
    .wr_data_i(wr_data), .wr_valid_i(wr_valid), .wr_ready_o(wr_ready), .word_sent_o(p_sent),
    .tc_o(p_tc), .pd_o(pd_o));
  lpcdw_chk #(.DMA_CH(CH)) lpcdw_chk_inst (.clock_i(clock_i), .srst_i(srst_i), .lad(bus_if.lad),
    .host_lad_oe(bus_if.host_lad_oe), .per_lad_oe(bus_if.per_lad_oe), .lframe_n(bus_if.lframe_n),
    .lreset_n(bus_if.lreset_n), .lpcpd_n(bus_if.lpcpd_n), .ldrq_oe(bus_if.ldrq_oe), .ldrq_n(bus_if.ldrq_n));

  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk_f(input string what, input logic e, input logic s);
    n_checks++;
    if (s !== e)
    begin
      miscompares++;
      $display("ERROR %s expected %b seen %b", what, e, s);
    end
  endtask

  task automatic chk_w(input string what, input logic [15:0] e, input logic [15:0] s);
    n_checks++;
    if (s !== e)
    begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", what, e, s);
    end
  endtask

  function automatic logic [31:0] nxt_rnd(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  // feeder holds valid and data until the buffer takes the word
  task automatic push(input int n);
    for (int i = 0; i < n; i++)
    begin
      lfsr = nxt_rnd(lfsr);
      wr_data <= lfsr[15:0];
      wr_valid <= 1'b1;
      do @(posedge clock_i); while (wr_ready !== 1'b1);
    end
    wr_valid <= 1'b0;
  endtask

  // n words asked of the host, n_eff expected before it stops
  task automatic run(input int n, input int n_eff);
    got = 0;
    wseq = 0;
    n_exp = n_eff;
    early = (n != n_eff);
    words <= n[7:0];
    start <= 1'b1;
    @(posedge clock_i);
    start <= 1'b0;
    for (int i = 0; i < 600 && got < n_eff; i++) @(posedge clock_i);
    chk_w("words moved", n_eff[15:0], got[15:0]);
  endtask

  task automatic wait_n(input int n);
    repeat (n) @(posedge clock_i);
  endtask

  task automatic end_sim();
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // model: accepted words queue up, the wire and both ends are held against it
  always @(posedge clock_i)
  begin
    if (srst_i === 1'b0)
    begin
      if (wr_valid === 1'b1 && wr_ready === 1'b1)
        exp_q.push_back(wr_data);
      cyc = (bus_if.lframe_n === 1'b0) ? 0 : (cyc >= 0 ? cyc + 1 : -1);
      if (cyc == 2)
      begin
        exp_tc = !early && (wseq == n_exp - 1);
        wseq++;
        chk_f("channel tc bit", exp_tc, bus_if.lad[3]);
      end
      if (exp_q.size() > 0 && (cyc == 7 || cyc == 8 || cyc == 10 || cyc == 11))
        chk_w("data nibble", (exp_q[0] >> (4 * (cyc - (cyc > 9 ? 8 : 7)))) & 16'h000F, {12'h000, bus_if.lad});
      if (p_sent === 1'b1)
        chk_f("periph tc", exp_tc, p_tc);
      if (h_done === 1'b1)
        dones++;
      if (h_valid === 1'b1)
      begin
        got++;
        chk_w("host word", exp_q.pop_front(), h_data);
        if (!early)
          chk_f("host tc", exp_tc, h_tc);
      end
    end
  end

  // hang guard, far above the few hundred cycles the tests need
  always @(posedge clock_i)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      miscompares++;
      end_sim();
    end
  end

  initial
  begin
    wait_n(3);
    srst_i <= 1'b0;
    wait_n(2);
    chk_f("request idle", 1'b1, bus_if.ldrq_n);
    chk_f("frame idle", 1'b1, bus_if.lframe_n);
    // feeder racing the transfer keeps more-sync on the first words
    fork
      push(3);
      run(3, 3);
    join
    $display("test stream finished");
    // buffer fills and refuses, then drains empty
    push(2);
    wait_n(4);
    chk_f("buffer full", 1'b0, wr_ready);
    run(2, 2);
    chk_f("buffer empty", 1'b1, wr_ready);
    $display("test buffer finished");
    // feeder dries up: done sync ends the transfer early
    dones = 0;
    push(2);
    run(4, 2);
    wait_n(4);
    chk_w("early done", 16'h0001, dones[15:0]);
    $display("test early finished");
    // power-down and back with no bus reset, a word waiting meanwhile
    pd_req <= 1'b1;
    wait_n(3);
    chk_f("pd level", 1'b1, pd_o);
    chk_f("request released", 1'b0, bus_if.ldrq_oe);
    chk_f("pd safe early", 1'b0, pd_safe);
    push(1);
    wait_n(25);
    chk_f("pd safe", 1'b1, pd_safe);
    chk_f("request quiet", 1'b1, bus_if.ldrq_n);
    pd_req <= 1'b0;
    wait_n(3);
    chk_f("request driven", 1'b1, bus_if.ldrq_oe);
    run(1, 1);
    $display("test powerdown finished");
    // bus reset idles the bus block but leaves the request line driven high
    bus_rst <= 1'b1;
    wait_n(3);
    chk_f("bus reset line", 1'b0, bus_if.lreset_n);
    chk_f("bus reset request", 1'b1, bus_if.ldrq_n);
    bus_rst <= 1'b0;
    wait_n(3);
    chk_f("bus reset exit", 1'b1, bus_if.ldrq_oe);
    $display("test busreset finished");
    end_sim();
  end
endmodule // lpc_dma_write_and_powerdown_test
